// ---- hw/pmrc_pkg.sv ----
// package: register map, field positions, reset values and timing counts for the power/reset control
package pmrc_pkg;
	// -------------------------------------------------------------------------
	// register byte offsets
	// -------------------------------------------------------------------------
	localparam logic [7:0] PMRC_OFS_MODE   = 8'h00; // global mode request / state
	localparam logic [7:0] PMRC_OFS_WAKEEN = 8'h04; // wakeup source enables
	localparam logic [7:0] PMRC_OFS_BOOST  = 8'h08; // boost mode and switching clock
	localparam logic [7:0] PMRC_OFS_MONCFG = 8'h0C; // low-voltage monitor config
	localparam logic [7:0] PMRC_OFS_WDOG   = 8'h10; // watchdog control
	localparam logic [7:0] PMRC_OFS_SWRST  = 8'h14; // software reset
	localparam logic [7:0] PMRC_OFS_RSTSTS = 8'h18; // reset cause status (write 1 clears)
	localparam logic [7:0] PMRC_OFS_STATUS = 8'h1C; // live state

	// -------------------------------------------------------------------------
	// global power modes
	// -------------------------------------------------------------------------
	typedef enum logic [1:0] {
		PMRC_ACTIVE    = 2'b00,
		PMRC_ALTACTIVE = 2'b01,
		PMRC_SLEEP     = 2'b10,
		PMRC_HIBERNATE = 2'b11
	} pmrc_mode_type;

	// -------------------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------------------
	localparam int PMRC_WAKE_PERIPH = 0; // wakeup enable bits
	localparam int PMRC_WAKE_SUPV   = 1;
	localparam int PMRC_WAKE_CTW    = 2;
	localparam int PMRC_WAKE_PIN    = 3;
	localparam int PMRC_BST_STBY    = 0; // boost: 1 = standby
	localparam int PMRC_BST_AUTO    = 1; // boost: auto pulse mode
	localparam int PMRC_BST_FSEL    = 2; // boost: clock select [3:2]
	localparam int PMRC_MON_ALVRST  = 0; // analog low-volt gives reset
	localparam int PMRC_MON_DLVRST  = 1; // digital low-volt gives reset
	localparam int PMRC_MON_AREGOFF = 2; // analog regulator disabled
	localparam int PMRC_MON_SWRDIS  = 3; // software reset disabled
	localparam int PMRC_SW_GO       = 0;
	localparam int PMRC_WD_EN       = 0;
	localparam int PMRC_WD_KICK     = 1;
	// reset status flags
	localparam int PMRC_RS_POR  = 0;
	localparam int PMRC_RS_PRECISE_LV_MONITOR = 1;
	localparam int PMRC_RS_EXT_RESET_N_PIN = 2;
	localparam int PMRC_RS_WDOG = 3;
	localparam int PMRC_RS_SW   = 4;
	localparam int PMRC_RS_ALV  = 5;
	localparam int PMRC_RS_DLV  = 6;
	localparam int PMRC_RS_AHV  = 7;

	// boost switching clock codes
	localparam logic [1:0] PMRC_F100K = 2'h0;
	localparam logic [1:0] PMRC_F400K = 2'h1;
	localparam logic [1:0] PMRC_F2M   = 2'h2;
	localparam logic [1:0] PMRC_F32K  = 2'h3;

	// -------------------------------------------------------------------------
	// reset values and timing
	// -------------------------------------------------------------------------
	localparam logic [3:0]  PMRC_WAKEEN_RST = 4'hF;
	localparam logic [3:0]  PMRC_BOOST_RST  = 4'h0;
	localparam logic [3:0]  PMRC_MONCFG_RST = 4'h0;
	localparam logic [15:0] PMRC_WD_DEF     = 16'h4000; // watchdog period in cycles
	localparam int PMRC_CLK_MHZ     = 40;
	localparam int PMRC_SLEEP_US    = 15;  // sleep resume interval
	localparam int PMRC_HIB_US      = 100; // hibernate resume upper bound
	localparam int PMRC_POR_NS      = 100; // least reset pulse
	localparam int PMRC_SLEEP_CYC   = PMRC_SLEEP_US * PMRC_CLK_MHZ;
	localparam int PMRC_HIB_CYC     = PMRC_HIB_US * PMRC_CLK_MHZ - 1;
	localparam int PMRC_POR_CYC     = (PMRC_POR_NS * PMRC_CLK_MHZ + 999) / 1000;
	localparam logic [7:0]  PMRC_HIB_WAIT = 8'h40; // hibernate resume, well under bound
endpackage : pmrc_pkg

// ---- hw/pmrc_top.sv ----
// power mode and reset controller with AHB-Lite register slave
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/100ps

module pmrc_top
	import pmrc_pkg::*;
(
	input  wire logic        sys_clk,          // 40 MHz clock
	input  wire logic        rstn,             // async reset, power-on level
	input  wire logic        hsel,             // ahb select
	input  wire logic [7:0]  haddr,            // ahb address
	input  wire logic [1:0]  htrans,           // ahb transfer type
	input  wire logic        hwrite,           // ahb write
	input  wire logic [2:0]  hsize,            // ahb size
	input  wire logic [31:0] hwdata,           // ahb write data
	input  wire logic        hready,           // ahb bus ready
	output logic      [31:0] hrdata,           // ahb read data
	output logic             hreadyout,        // ahb slave ready
	output logic             hresp,            // ahb response, always okay
	input  wire logic        supplyRamping,    // a supply is still ramping
	input  wire logic        vddStable,        // internal digital supply stable
	input  wire logic        supplyFault,      // any supply out of range
	input  wire logic        presDigTrip,      // precise monitor digital trip
	input  wire logic        presAnaTrip,      // precise monitor analog trip
	input  wire logic        extResetN,        // external reset pin, active low
	input  wire logic        analogLowVolt,    // analog low-voltage detect
	input  wire logic        digitalLowVolt,   // digital low-voltage detect
	input  wire logic        analogHighVolt,   // analog high-voltage detect
	input  wire logic        wakePeriph,       // peripheral interrupt
	input  wire logic        wakeCtw,          // central timewheel tick
	input  wire logic        wakePin,          // pin interrupt
	input  wire logic        buzzWindow,       // sleep regulator activation window
	input  wire logic        xtal32k,          // 32 kHz crystal, sampled
	input  wire logic        boostBelow,       // boost output below target
	output logic             devResetN,        // device reset, active low
	output logic             porMonEn,         // power-on monitor enabled
	output logic             presDigEn,        // precise monitor digital enable
	output logic             presAnaEn,        // precise monitor analog enable
	output logic             oscEn,            // main internal oscillator enable
	output logic             cpuEn,            // cpu enable
	output logic             retainHold,       // hold config, sram, pins in hibernate
	output logic [1:0]       globalMode,       // current mode
	output logic             boostStandby,     // boost in standby
	output logic [1:0]       boostFsel,        // boost clock select
	output logic             boostPulse,       // auto pulse mode inductor pulse
	output logic             supvIrq           // monitor interrupt to cpu
);
	// -------------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------------
	typedef enum logic [1:0] {
		PMRC_SQ_RUN  = 2'b00,
		PMRC_SQ_WAKE = 2'b01,
		PMRC_SQ_RST  = 2'b10
	} pmrc_seq_type;

	typedef struct packed {
		pmrc_mode_type mode;
		pmrc_seq_type  seq;
		logic [11:0]   cnt;
		logic [15:0]   wdCnt;
		logic          wdEn;
		logic [3:0]    wakeEn;
		logic [3:0]    boost;
		logic [3:0]    monCfg;
		logic [7:0]    rstSts;
		logic          porDone;
		logic          pendIrq;
		logic          xtalD;
		logic          aPh;
		logic          aWr;
		logic [7:0]    aAdr;
		logic [31:0]   rdata;
		logic          resetN;
		logic          porEn;
		logic          presD;
		logic          presA;
		logic          osc;
		logic          cpu;
		logic          hold;
		logic          bStby;
		logic [1:0]    bFs;
		logic          pulse;
		logic          irq;
	} pmrc_state_type;

	pmrc_state_type st_r;
	pmrc_state_type st_nxt;

	localparam logic [11:0] SLEEP_CNT = 12'(PMRC_SLEEP_CYC);
	localparam logic [11:0] POR_CNT   = 12'(PMRC_POR_CYC);
	localparam logic [11:0] HIB_CNT   = {4'h0, PMRC_HIB_WAIT};

	// word offset match
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a[7:2] == ofs[7:2];
	endfunction

	// -------------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------------
	always_comb begin
		logic resetReq;
		logic wake;
		logic wrGo;
		logic presTrip;
		logic lvIrq;
		resetReq = 1'b0;
		wake     = 1'b0;
		st_nxt   = st_r;
		wrGo     = st_r.aPh && st_r.aWr;
		// precise monitor counts only while enabled
		presTrip = (st_r.presD && presDigTrip) || (st_r.presA && presAnaTrip);
		lvIrq    = (analogLowVolt && !st_r.monCfg[PMRC_MON_ALVRST])
			|| (digitalLowVolt && !st_r.monCfg[PMRC_MON_DLVRST])
			|| analogHighVolt; // high-volt has no reset option

		// register bus address phase capture
		st_nxt.aPh = hsel && hready && htrans[1];
		st_nxt.aWr = hwrite;
		st_nxt.aAdr = haddr;
		st_nxt.rdata = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			if (hit(haddr, PMRC_OFS_MODE))   st_nxt.rdata = {30'h0, st_r.mode};
			if (hit(haddr, PMRC_OFS_WAKEEN)) st_nxt.rdata = {28'h0, st_r.wakeEn};
			if (hit(haddr, PMRC_OFS_BOOST))  st_nxt.rdata = {28'h0, st_r.boost};
			if (hit(haddr, PMRC_OFS_MONCFG)) st_nxt.rdata = {28'h0, st_r.monCfg};
			if (hit(haddr, PMRC_OFS_WDOG))   st_nxt.rdata = {31'h0, st_r.wdEn};
			if (hit(haddr, PMRC_OFS_RSTSTS)) st_nxt.rdata = {24'h0, st_r.rstSts};
			if (hit(haddr, PMRC_OFS_STATUS))
				st_nxt.rdata = {24'h0, st_r.irq, st_r.osc, st_r.porDone, st_r.seq, st_r.cpu, st_r.mode};
		end

		// register writes
		if (wrGo) begin
			if (hit(st_r.aAdr, PMRC_OFS_MODE) && st_r.seq == PMRC_SQ_RUN)
				st_nxt.mode = pmrc_mode_type'(hwdata[1:0]); // mode entry only by write
			if (hit(st_r.aAdr, PMRC_OFS_WAKEEN)) st_nxt.wakeEn = hwdata[3:0];
			if (hit(st_r.aAdr, PMRC_OFS_BOOST))  st_nxt.boost = hwdata[3:0];
			// analog regulator off is allowed; digital precise part has no disable
			if (hit(st_r.aAdr, PMRC_OFS_MONCFG)) st_nxt.monCfg = hwdata[3:0];
			if (hit(st_r.aAdr, PMRC_OFS_WDOG)) begin
				if (hwdata[PMRC_WD_EN]) st_nxt.wdEn = 1'b1; // sticky until power-on
				if (hwdata[PMRC_WD_KICK]) st_nxt.wdCnt = PMRC_WD_DEF;
			end
			if (hit(st_r.aAdr, PMRC_OFS_SWRST) && hwdata[PMRC_SW_GO]
				&& !st_r.monCfg[PMRC_MON_SWRDIS]) begin
				resetReq = 1'b1;
				st_nxt.rstSts[PMRC_RS_SW] = 1'b1;
			end
			if (hit(st_r.aAdr, PMRC_OFS_RSTSTS))
				st_nxt.rstSts = st_r.rstSts & ~hwdata[7:0]; // write one clears
		end

		// watchdog countdown
		if (st_r.wdEn && st_r.seq == PMRC_SQ_RUN && !(wrGo && hit(st_r.aAdr, PMRC_OFS_WDOG)
			&& hwdata[PMRC_WD_KICK])) begin
			if (st_r.wdCnt == 16'h0000) begin
				resetReq = 1'b1;
				st_nxt.rstSts[PMRC_RS_WDOG] = 1'b1;
			end else begin
				st_nxt.wdCnt = st_r.wdCnt - 16'h0001;
			end
		end

		// reset sources, sets win over software clear
		if (supplyFault) begin
			resetReq = 1'b1;
			st_nxt.rstSts[PMRC_RS_PRECISE_LV_MONITOR] = 1'b1;
		end
		if (presTrip) begin
			resetReq = 1'b1; // same path as power-on
			st_nxt.rstSts[PMRC_RS_PRECISE_LV_MONITOR] = 1'b1;
		end
		if (!extResetN) begin
			resetReq = 1'b1; // held while pin low
			st_nxt.rstSts[PMRC_RS_EXT_RESET_N_PIN] = 1'b1;
		end
		if (analogLowVolt) st_nxt.rstSts[PMRC_RS_ALV] = 1'b1;
		if (digitalLowVolt) st_nxt.rstSts[PMRC_RS_DLV] = 1'b1;
		if (analogHighVolt) st_nxt.rstSts[PMRC_RS_AHV] = 1'b1;
		if ((analogLowVolt && st_r.monCfg[PMRC_MON_ALVRST])
			|| (digitalLowVolt && st_r.monCfg[PMRC_MON_DLVRST]))
			resetReq = 1'b1;

		// wakeup decode per mode
		case (st_r.mode)
			PMRC_HIBERNATE: wake = wakePin && st_r.wakeEn[PMRC_WAKE_PIN];
			PMRC_SLEEP, PMRC_ALTACTIVE: wake = (wakePeriph && st_r.wakeEn[PMRC_WAKE_PERIPH])
				|| (lvIrq && st_r.wakeEn[PMRC_WAKE_SUPV])
				|| (wakeCtw && st_r.wakeEn[PMRC_WAKE_CTW])
				|| (wakePin && st_r.wakeEn[PMRC_WAKE_PIN]);
			default: wake = 1'b0;
		endcase

		// monitor interrupt held while asleep, presented after wakeup
		if (lvIrq) st_nxt.pendIrq = 1'b1;
		st_nxt.irq = st_r.pendIrq && st_r.mode == PMRC_ACTIVE && st_r.seq == PMRC_SQ_RUN;
		if (st_r.irq) st_nxt.pendIrq = lvIrq;

		// mode sequencer
		case (st_r.seq)
			PMRC_SQ_RST: begin
				// stretch at least the pulse width, and while supplies ramp
				if (st_r.cnt != 12'h000) st_nxt.cnt = st_r.cnt - 12'h001;
				if (resetReq || supplyRamping) st_nxt.cnt = POR_CNT;
				else if (st_r.cnt == 12'h000) begin
					st_nxt.seq = PMRC_SQ_RUN;
					st_nxt.mode = PMRC_ACTIVE; // boot in active
				end
			end
			PMRC_SQ_WAKE: begin
				if (resetReq) begin
					st_nxt.seq = PMRC_SQ_RST;
					st_nxt.cnt = POR_CNT;
				end else if (st_r.cnt == 12'h000) begin
					st_nxt.seq = PMRC_SQ_RUN;
					st_nxt.mode = PMRC_ACTIVE;
				end else st_nxt.cnt = st_r.cnt - 12'h001;
			end
			PMRC_SQ_RUN: begin
				if (resetReq) begin
					st_nxt.seq = PMRC_SQ_RST; // reset also wakes
					st_nxt.cnt = POR_CNT;
				end else if (wake && st_r.mode == PMRC_SLEEP) begin
					st_nxt.seq = PMRC_SQ_WAKE;
					st_nxt.cnt = SLEEP_CNT - 12'h001;
				end else if (wake && st_r.mode == PMRC_HIBERNATE) begin
					st_nxt.seq = PMRC_SQ_WAKE;
					st_nxt.cnt = HIB_CNT; // well under 100 us
				end else if (wake) begin
					st_nxt.mode = PMRC_ACTIVE;
				end
			end
			default: st_nxt.seq = PMRC_SQ_RST;
		endcase

		// device reset reloads control registers except watchdog enable, status survives
		if (st_r.seq == PMRC_SQ_RST) begin
			st_nxt.wakeEn = PMRC_WAKEEN_RST;
			st_nxt.boost  = PMRC_BOOST_RST;
			st_nxt.monCfg = PMRC_MONCFG_RST;
			st_nxt.wdCnt  = PMRC_WD_DEF;
			st_nxt.pendIrq = 1'b0;
		end

		// supervision handover
		if (vddStable) st_nxt.porDone = 1'b1;
		st_nxt.porEn = !st_nxt.porDone;
		// precise monitor runs when awake or during activation windows
		st_nxt.presD = st_nxt.porDone && (st_nxt.mode == PMRC_ACTIVE
			|| st_nxt.mode == PMRC_ALTACTIVE || st_nxt.seq == PMRC_SQ_RST
			|| (st_nxt.mode == PMRC_SLEEP && buzzWindow));
		st_nxt.presA = st_nxt.presD && !st_nxt.monCfg[PMRC_MON_AREGOFF];
		st_nxt.resetN = st_nxt.seq != PMRC_SQ_RST;
		st_nxt.osc = st_nxt.porDone && st_nxt.resetN; // after precise release
		// cpu on in active regardless of template after wake
		st_nxt.cpu = st_nxt.resetN && st_nxt.seq == PMRC_SQ_RUN
			&& st_nxt.mode != PMRC_SLEEP && st_nxt.mode != PMRC_HIBERNATE;
		st_nxt.hold = st_nxt.mode == PMRC_HIBERNATE;

		// boost control
		st_nxt.bStby = st_nxt.boost[PMRC_BST_STBY] && st_nxt.mode != PMRC_HIBERNATE;
		st_nxt.bFs = st_nxt.boost[PMRC_BST_FSEL+1:PMRC_BST_FSEL];
		st_nxt.xtalD = xtal32k;
		st_nxt.pulse = st_r.boost[PMRC_BST_AUTO] && (xtal32k != st_r.xtalD) && boostBelow;
	end

	// -------------------------------------------------------------------------
	// state register; power-on level resets everything incl. status
	// -------------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '{mode: PMRC_ACTIVE, seq: PMRC_SQ_RST, cnt: POR_CNT, wdCnt: PMRC_WD_DEF,
				wakeEn: PMRC_WAKEEN_RST, boost: PMRC_BOOST_RST, monCfg: PMRC_MONCFG_RST,
				porEn: 1'b1, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from flops, except hreadyout and hresp tied off
	assign hrdata       = st_r.rdata;
	assign hreadyout    = 1'b1;
	assign hresp        = 1'b0;
	assign devResetN    = st_r.resetN;
	assign porMonEn     = st_r.porEn;
	assign presDigEn    = st_r.presD;
	assign presAnaEn    = st_r.presA;
	assign oscEn        = st_r.osc;
	assign cpuEn        = st_r.cpu;
	assign retainHold   = st_r.hold;
	assign globalMode   = st_r.mode;
	assign boostStandby = st_r.bStby;
	assign boostFsel    = st_r.bFs;
	assign boostPulse   = st_r.pulse;
	assign supvIrq      = st_r.irq;
endmodule // pmrc_top

// ---- sim/pmrc_monitor.sv ----
// port checker for the power mode and reset controller
`timescale 1ns/100ps
module pmrc_monitor
	import pmrc_pkg::*;
(
	input wire logic       sys_clk,       // clock
	input wire logic       rstn,          // power-on reset
	input wire logic       supplyRamping, // supply ramping
	input wire logic       vddStable,     // supply stable
	input wire logic       supplyFault,   // supply fault
	input wire logic       extResetN,     // reset pin
	input wire logic       wakePin,       // pin wake
	input wire logic       buzzWindow,    // sleep window
	input wire logic       devResetN,     // device reset
	input wire logic       porMonEn,      // power-on monitor on
	input wire logic       presDigEn,     // precise digital on
	input wire logic       presAnaEn,     // precise analog on
	input wire logic       oscEn,         // oscillator on
	input wire logic       retainHold,    // retention hold
	input wire logic [1:0] globalMode,    // mode
	input wire logic       boostStandby,  // boost standby
	input wire logic       boostPulse     // boost pulse
);
	localparam int HIB_MAX = 3999;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic [11:0] hibWait_r;
	// cycles spent in hibernate with the wake pin up
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) hibWait_r <= 12'h000;
		else if (globalMode == PMRC_HIBERNATE && wakePin) hibWait_r <= hibWait_r + 12'h001;
		else hibWait_r <= 12'h000;
	end
	// ------------------------------
	// reset sources
	// ------------------------------
	pin_reset_a: assert property (!extResetN |=> !devResetN)
		else $error("pin reset missed");
	fault_reset_a: assert property (supplyFault |=> !devResetN)
		else $error("fault reset missed");
	ramp_stretch_a: assert property (supplyRamping |=> !devResetN)
		else $error("reset released while ramping");
	por_handoff_a: assert property ($rose(vddStable) |-> ##[1:16] !porMonEn)
		else $error("power-on monitor left on");
	osc_order_a: assert property (!vddStable |=> !oscEn)
		else $error("oscillator started early");
	boot_active_a: assert property ($rose(devResetN) |-> globalMode == PMRC_ACTIVE)
		else $error("boot mode not active");
	// ------------------------------
	// low power modes and boost
	// ------------------------------
	hib_boost_a: assert property ((globalMode == PMRC_HIBERNATE &&
		$past(globalMode) == PMRC_HIBERNATE) |-> !boostStandby)
		else $error("boost standby while hibernating");
	hib_retain_a: assert property ((globalMode == PMRC_HIBERNATE &&
		$past(globalMode) == PMRC_HIBERNATE) |-> retainHold)
		else $error("retention dropped");
	hib_resume_a: assert property (hibWait_r < 12'(HIB_MAX))
		else $error("hibernate resume too slow");
	sleep_precise_lv_monitor_a: assert property ((globalMode == PMRC_SLEEP &&
		$past(globalMode) == PMRC_SLEEP && !buzzWindow) |-> !presDigEn && !presAnaEn)
		else $error("precise monitor on in sleep");
	pulse_single_a: assert property (boostPulse |=> !boostPulse)
		else $error("boost pulse too long");
	// main scenarios
	cover property ($fell(globalMode == PMRC_SLEEP));
	cover property ($fell(globalMode == PMRC_HIBERNATE));
	cover property (boostPulse);
	cover property ($fell(devResetN));
endmodule // pmrc_monitor

// ---- sim/pmrc_supply_model.sv ----
// partner model: supplies, reset pin, wake sources and crystal
`timescale 1ns/100ps
module pmrc_supply_model #(
	parameter int RAMP  = 12, // supply ramp in cycles
	parameter int XHALF = 8   // crystal half period, shortened
) (
	input  wire logic       sys_clk,        // clock
	input  wire logic       rstn,           // power-on
	input  wire logic       faultReq,       // supply fault request
	input  wire logic       pinRstReq,      // pull reset pin low
	input  wire logic [2:0] wakeReq,        // periph, timewheel, pin
	input  wire logic [2:0] lvReq,          // analog low, digital low, analog high
	input  wire logic       xtalRun,        // crystal running
	input  wire logic       belowReq,       // boost under target
	output logic            supplyRamping,  // ramping
	output logic            vddStable,      // stable
	output logic            supplyFault,    // fault
	output logic            extResetN,      // reset pin
	output logic [2:0]      lowVolt,        // monitor detects
	output logic [2:0]      wake,           // wake lines
	output logic            xtal32k,        // crystal
	output logic            boostBelow      // boost under target
);
	logic [7:0] rampCnt_r;
	logic [7:0] xtalCnt_r;
	// supply ramp and crystal
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rampCnt_r <= 8'h00;
			xtalCnt_r <= 8'h00;
			xtal32k   <= 1'b0;
		end else begin
			if (rampCnt_r < 8'(RAMP + 4)) rampCnt_r <= rampCnt_r + 8'h01;
			if (xtalRun) begin
				xtalCnt_r <= (xtalCnt_r == 8'(XHALF - 1)) ? 8'h00 : xtalCnt_r + 8'h01;
				if (xtalCnt_r == 8'(XHALF - 1)) xtal32k <= ~xtal32k;
			end
		end
	end
	// supply levels and request lines
	assign supplyRamping = !rstn || rampCnt_r < 8'(RAMP);
	assign vddStable     = rampCnt_r >= 8'(RAMP + 4);
	assign supplyFault   = faultReq;
	assign extResetN     = !pinRstReq; // pull-up when released
	assign lowVolt       = lvReq;
	assign wake          = wakeReq;
	assign boostBelow    = belowReq;
endmodule // pmrc_supply_model

// ---- sim/test_power_mode_reset_control.sv ----
// testbench for the power mode and reset controller
`timescale 1ns/100ps
module test_power_mode_reset_control import pmrc_pkg::*; ;
	logic        sys_clk, rstn, hsel, hwrite, faultReq, pinRstReq, xtalRun, belowReq;
	logic        hreadyout, hresp, ramp, stable, fault, extN, xtal, below, devResetN, porMonEn;
	logic        presDigEn, presAnaEn, oscEn, cpuEn, retainHold, boostStandby, boostPulse, supvIrq;
	logic [7:0]  haddr;
	logic [1:0]  htrans, globalMode, boostFsel;
	logic [2:0]  hsize, wakeReq, lvReq, lv, wk;
	logic [31:0] hwdata, hrdata, q, stsExp;
	int          n_errors, n_checks, cnt;
	pmrc_top u_pmrc_top (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .supplyRamping(ramp),
		.vddStable(stable), .supplyFault(fault), .presDigTrip(1'b0), .presAnaTrip(1'b0),
		.extResetN(extN), .analogLowVolt(lv[0]), .digitalLowVolt(lv[1]), .analogHighVolt(lv[2]),
		.wakePeriph(wk[0]), .wakeCtw(wk[1]), .wakePin(wk[2]), .buzzWindow(1'b0), .xtal32k(xtal),
		.boostBelow(below), .devResetN(devResetN), .porMonEn(porMonEn), .presDigEn(presDigEn),
		.presAnaEn(presAnaEn), .oscEn(oscEn), .cpuEn(cpuEn), .retainHold(retainHold),
		.globalMode(globalMode), .boostStandby(boostStandby), .boostFsel(boostFsel),
		.boostPulse(boostPulse), .supvIrq(supvIrq));
	pmrc_supply_model u_pmrc_supply_model (.sys_clk(sys_clk), .rstn(rstn), .faultReq(faultReq),
		.pinRstReq(pinRstReq), .wakeReq(wakeReq), .lvReq(lvReq), .xtalRun(xtalRun),
		.belowReq(belowReq), .supplyRamping(ramp), .vddStable(stable), .supplyFault(fault),
		.extResetN(extN), .lowVolt(lv), .wake(wk), .xtal32k(xtal), .boostBelow(below));
	// clock at 40 MHz
	always #12.5 sys_clk = ~sys_clk;
	// ------------------------------
	// helpers
	// ------------------------------
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask
	function automatic logic [1:0] sig(input int sel);
		case (sel)
			0: return {1'b0, devResetN};
			1: return globalMode;
			default: return {1'b0, supvIrq};
		endcase
	endfunction
	// bounded wait; a hang ends the run
	task automatic waitFor(input int sel, input logic [1:0] want, input int lim);
		cnt = 0;
		while (sig(sel) !== want && cnt < lim) begin
			@(posedge sys_clk);
			cnt++;
		end
		if (cnt >= lim) begin
			$display("BAD wait %0d expected %h seen %h", sel, want, sig(sel));
			n_errors++;
			tally_and_finish();
		end
	endtask
	// single ahb transfer
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
		do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 20);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 40);
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(a, 1'b0, 32'h0);
		chk(what, exp, q);
	endtask
	// wait out a reset, check its flag
	task automatic rstDone(input int bitNo);
		waitFor(0, 2'h0, 100);
		faultReq <= 1'b0; pinRstReq <= 1'b0; lvReq <= 3'h0;
		waitFor(0, 2'h1, 300);
		stsExp = stsExp | (32'h1 << bitNo);
		rd(PMRC_OFS_RSTSTS, stsExp, "rststs");
	endtask
	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		sys_clk = 0; rstn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
		hsize = 3'h2; faultReq = 0; pinRstReq = 0; wakeReq = 0; lvReq = 0; xtalRun = 0;
		belowReq = 0; n_errors = 0; n_checks = 0; stsExp = 0; q = 0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		waitFor(0, 2'h1, 300);
		rd(PMRC_OFS_WAKEEN, 32'h0000000F, "wakeen");
		rd(PMRC_OFS_BOOST, 32'h0, "boost");
		rd(PMRC_OFS_MONCFG, 32'h0, "moncfg");
		rd(PMRC_OFS_RSTSTS, 32'h0, "rststs");
		bus(8'h40, 1'b1, 32'hFFFFFFFF);
		rd(8'h40, 32'h0, "unmapped");
		// boost clock codes, standby
		for (int i = 0; i < 4; i++) begin
			bus(PMRC_OFS_BOOST, 1'b1, 32'(i * 4 + 1));
			repeat (3) @(posedge sys_clk);
			chk("boostFsel", 32'(i), {30'h0, boostFsel});
			chk("boostStandby", 32'h1, {31'h0, boostStandby});
		end
		// auto pulses on crystal edges
		bus(PMRC_OFS_BOOST, 1'b1, 32'h2);
		belowReq <= 1'b1; xtalRun <= 1'b1;
		repeat (4) @(posedge sys_clk);
		cnt = 0;
		repeat (160) begin @(posedge sys_clk); if (boostPulse === 1'b1) cnt++; end
		chk("pulses", 32'h1, 32'(cnt >= 19 && cnt <= 21));
		belowReq <= 1'b0;
		repeat (8) @(posedge sys_clk);
		cnt = 0;
		repeat (64) begin @(posedge sys_clk); if (boostPulse === 1'b1) cnt++; end
		chk("pulses idle", 32'h0, 32'(cnt));
		xtalRun <= 1'b0;
		// sleep, peripheral wake
		bus(PMRC_OFS_MODE, 1'b1, 32'h2);
		waitFor(1, PMRC_SLEEP, 20);
		wakeReq <= 3'b001;
		waitFor(1, PMRC_ACTIVE, 800);
		chk("sleep wait", 32'h1, 32'(cnt >= PMRC_SLEEP_CYC && cnt <= PMRC_SLEEP_CYC + 8));
		wakeReq <= 3'b000;
		// hibernate, pin wake only
		bus(PMRC_OFS_BOOST, 1'b1, 32'h1);
		bus(PMRC_OFS_MODE, 1'b1, 32'h3);
		waitFor(1, PMRC_HIBERNATE, 20);
		wakeReq <= 3'b011;
		repeat (200) @(posedge sys_clk);
		chk("hib mode", 32'(PMRC_HIBERNATE), {30'h0, globalMode});
		chk("hib boost", 32'h0, {31'h0, boostStandby});
		chk("hib retain", 32'h1, {31'h0, retainHold});
		wakeReq <= 3'b100;
		waitFor(1, PMRC_ACTIVE, PMRC_HIB_US * PMRC_CLK_MHZ);
		wakeReq <= 3'b000;
		repeat (5) @(posedge sys_clk);
		chk("cpuEn", 32'h1, {31'h0, cpuEn});
		rd(PMRC_OFS_BOOST, 32'h1, "boost kept");
		// alt active, timewheel wake
		bus(PMRC_OFS_MODE, 1'b1, 32'h1);
		waitFor(1, PMRC_ALTACTIVE, 20);
		wakeReq <= 3'b010;
		waitFor(1, PMRC_ACTIVE, 20);
		wakeReq <= 3'b000;
		// software reset refused, then taken
		bus(PMRC_OFS_MONCFG, 1'b1, 32'h8);
		bus(PMRC_OFS_SWRST, 1'b1, 32'h1);
		repeat (20) @(posedge sys_clk);
		chk("swrst off", 32'h1, {31'h0, devResetN});
		bus(PMRC_OFS_MONCFG, 1'b1, 32'h0);
		bus(PMRC_OFS_SWRST, 1'b1, 32'h1);
		rstDone(PMRC_RS_SW);
		rd(PMRC_OFS_BOOST, 32'h0, "boost reset");
		pinRstReq <= 1'b1;
		repeat (100) @(posedge sys_clk);
		chk("pin held", 32'h0, {31'h0, devResetN});
		rstDone(PMRC_RS_EXT_RESET_N_PIN);
		faultReq <= 1'b1;
		rstDone(PMRC_RS_PRECISE_LV_MONITOR);
		// low-volt detects as resets
		for (int i = 0; i < 2; i++) begin
			bus(PMRC_OFS_MONCFG, 1'b1, 32'h1 << i);
			lvReq <= 3'(1 << i);
			rstDone(PMRC_RS_ALV + i);
		end
		// high-volt gives an irq only
		lvReq <= 3'b100;
		waitFor(2, 2'h1, 20);
		lvReq <= 3'b000;
		chk("ahv no reset", 32'h1, {31'h0, devResetN});
		stsExp = stsExp | (32'h1 << PMRC_RS_AHV);
		rd(PMRC_OFS_RSTSTS, stsExp, "rststs ahv");
		// watchdog never kicked
		bus(PMRC_OFS_WDOG, 1'b1, 32'h1);
		waitFor(0, 2'h0, 17000);
		chk("wdog period", 32'h1, 32'(cnt >= 16320 && cnt <= 16448));
		rstDone(PMRC_RS_WDOG);
		// power-on clears the status
		rstn <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		waitFor(0, 2'h1, 300);
		rd(PMRC_OFS_RSTSTS, 32'h0, "rststs por");
		tally_and_finish();
	end
endmodule // test_power_mode_reset_control

bind pmrc_top pmrc_monitor u_pmrc_monitor (.sys_clk(sys_clk), .rstn(rstn),
	.supplyRamping(supplyRamping), .vddStable(vddStable), .supplyFault(supplyFault),
	.extResetN(extResetN), .wakePin(wakePin), .buzzWindow(buzzWindow), .devResetN(devResetN),
	.porMonEn(porMonEn), .presDigEn(presDigEn), .presAnaEn(presAnaEn), .oscEn(oscEn),
	.retainHold(retainHold), .globalMode(globalMode), .boostStandby(boostStandby),
	.boostPulse(boostPulse));
